// ==== logic/fsu_regs.svh ====
// fsu_regs.svh: offsets, reset values and timing counts of the fault supervisor
// assumes a 50 MHz controller clock; included by bare name
`ifndef FSU_REGS_SVH
`define FSU_REGS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define FSU_CLK_MHZ 50

// ----------------------------------------
// programming protocol times
// ----------------------------------------
`define FSU_ENTRY_NS 10000
`define FSU_ENTRY_CYC ((`FSU_ENTRY_NS * `FSU_CLK_MHZ + 999) / 1000)
`define FSU_GAP_NS 8000
`define FSU_GAP_CYC ((`FSU_GAP_NS * `FSU_CLK_MHZ + 999) / 1000)
`define FSU_BIT_PERIOD_NS 1000
`define FSU_BIT_PERIOD_CYC ((`FSU_BIT_PERIOD_NS * `FSU_CLK_MHZ) / 1000)
`define FSU_BIT_ONE_MIN (`FSU_BIT_PERIOD_CYC / 2)
`define FSU_BIT_MAX_CYC (`FSU_BIT_PERIOD_CYC * 4)
`define FSU_COMMIT_MS 15
`define FSU_COMMIT_CYC (`FSU_COMMIT_MS * 1000 * `FSU_CLK_MHZ)

// ----------------------------------------
// word layout and counts
// ----------------------------------------
`define FSU_WORD_PULSES 7
`define FSU_ADDR_BITS 6
`define FSU_ADDR_ZERO_BITS 4
`define FSU_HICCUP_CYCLES 7
`define FSU_OCP_CYCLES 7
`define FSU_TRIM_RESET 4'h0
`define FSU_TRIM_STEP_MV 2
`define FSU_TRIM_TOP_MV 14

`endif

// ==== logic/fsu_pkg.sv ====
// fsu_pkg: types shared by the fault supervisor and trim port
// assumes nothing of its surroundings
package fsu_pkg;

	// ----------------------------------------
	// digitised comparator results
	// ----------------------------------------
	typedef struct packed {
		logic fb_under_uv;
		logic fb_over_ov;
		logic fb_out_of_band;
		logic temp_over_warn;
		logic temp_over_shutdown;
		logic temp_below_reset;
		logic comp_over_limit;
	} fsu_sense_s;

	typedef struct packed {
		logic trim_sign_bit;
		logic trim_bit_two;
		logic trim_bit_one;
		logic trim_bit_zero;
	} fsu_trim_s;

	// ----------------------------------------
	// state machines
	// ----------------------------------------
	typedef enum logic [5:0] {
		SUP_OFF = 6'b000001,
		SUP_START = 6'b000010,
		SUP_RUN = 6'b000100,
		SUP_HICCUP = 6'b001000,
		SUP_OV_HOLD = 6'b010000,
		SUP_THERMAL = 6'b100000
	} fsu_sup_e;

	typedef enum logic [2:0] {
		PRG_IDLE = 3'b001,
		PRG_GAP = 3'b010,
		PRG_BITS = 3'b100
	} fsu_prog_e;

endpackage : fsu_pkg

// ==== logic/fsu_sync.sv ====
// fsu_sync: two-stage synchroniser for a vector of levels
// assumes inputs are slow levels from comparators
`timescale 1ns/100ps
module fsu_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// first stage feeds only the second stage
	logic [WIDTH-1:0] meta_reg;

	if (WIDTH < 1) begin : g_bad_width
		$error("fsu_sync: WIDTH must be positive");
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : fsu_sync

// ==== logic/fsu_pulse_meter.sv ====
// fsu_pulse_meter: measures high and low times of the lockout pin
// assumes a synchronised level on the controller clock
`timescale 1ns/100ps
`include "fsu_regs.svh"
module fsu_pulse_meter #(
	parameter int CNT_W = 10,
	parameter int ONE_MIN = `FSU_BIT_ONE_MIN
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic level_high,
	output logic pulse_end,
	output logic pulse_is_one,
	output logic [CNT_W-1:0] pulse_len,
	output logic [CNT_W-1:0] low_len
);
	logic level_reg;
	logic [CNT_W-1:0] hi_cnt_reg;
	logic [CNT_W-1:0] hi_cnt_next;
	logic [CNT_W-1:0] low_next;
	wire fall = level_reg & ~level_high;
	wire hi_sat = &hi_cnt_reg;
	wire low_sat = &low_len;

	if (ONE_MIN < 1 || ONE_MIN >= (1 << CNT_W)) begin : g_bad_one_min
		$error("fsu_pulse_meter: ONE_MIN out of range");
	end

	// saturating counts, so a stuck pin cannot wrap into a legal width
	assign hi_cnt_next = level_high ? (hi_sat ? hi_cnt_reg : hi_cnt_reg + 1'b1) : '0;
	assign low_next = level_high ? '0 : (low_sat ? low_len : low_len + 1'b1);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level_reg <= 1'b0;
			hi_cnt_reg <= '0;
			low_len <= '0;
			pulse_end <= 1'b0;
			pulse_is_one <= 1'b0;
			pulse_len <= '0;
		end else begin
			level_reg <= level_high;
			hi_cnt_reg <= hi_cnt_next;
			low_len <= low_next;
			pulse_end <= fall;
			if (fall) begin
				pulse_len <= hi_cnt_reg;
				pulse_is_one <= (hi_cnt_reg >= CNT_W'(ONE_MIN));
			end
		end
	end
endmodule : fsu_pulse_meter

// ==== logic/fsu_fault_trim.sv ====
// fsu_fault_trim: fault supervisor, power-good pin and reference trim port
// assumes comparator results arrive as levels; soft start and switch pulses are synchronous
//
// Function
// - master: power good low on band, soft start, lockout, short, warm die
// - loop slave: power good low only on lockout or warm die
// - undervoltage: both transistors off, hiccup restart like any fault but overtemperature
// - undervoltage restart resets prebias logic to keep prebiased output
// - overvoltage: high side off, low side on until below undervoltage
// - after overvoltage drops below undervoltage, enter hiccup recovery
// - overvoltage protection armed in every enabled state except thermal shutdown
// - overtemperature shutdown until cooled below reset level, then auto restart
// - four-bit trim code maps to plus or minus fourteen mV in 2 mV steps
// - programming reaches only the reference trim bits, even when malformed
// - trim buffer loads the stored value at power-up
// - long entry pulse then intermediate gap opens a session
// - seven pulses per write, six address then one data, width decides
// - write accepted only with four leading zero address bits; two select bit
// - accepted write updates buffer; reference follows without store write
// - power good high plus lockout high for commit time writes store
// - uncommitted buffer lost at power cycling, reverts to stored value
// - committed value persists yet is replaceable by later commits
// - hiccup runs seven soft-start cycles without switching, then restarts
// - overcurrent after limit exceeded for seven consecutive switching cycles
`timescale 1ns/100ps
`include "fsu_regs.svh"
module fsu_fault_trim #(
	parameter int COMMIT_CYC = `FSU_COMMIT_CYC,
	parameter int CNT_W = 10,
	parameter int BIT_ONE_MIN = `FSU_BIT_ONE_MIN
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ctrl_enable,
	input wire logic loop_slave,
	input wire logic lockout_active,
	input wire fsu_pkg::fsu_sense_s sense_in,
	input wire logic switch_cycle,
	input wire logic soft_start_done,
	input wire logic lockout_program_pin_elev,
	input wire logic lockout_program_pin_high,
	input wire logic power_good_pin_hv,
	input wire fsu_pkg::fsu_trim_s nv_stored_code,
	output logic power_good_out,
	output logic power_good_pin_out,
	output logic power_good_pin_oe,
	output logic high_side_en,
	output logic low_side_en,
	output logic soft_start_run,
	output logic prebias_reset,
	output logic hiccup_active,
	output logic thermal_off,
	output fsu_pkg::fsu_trim_s ref_trim_code,
	output logic signed [4:0] ref_offset_mv,
	output logic nv_write_pulse,
	output fsu_pkg::fsu_trim_s nv_write_data
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (COMMIT_CYC < 1 || COMMIT_CYC >= (1 << 20) || CNT_W < 10) begin : g_bad_param
		$error("fsu_fault_trim: COMMIT_CYC out of range or CNT_W too small for entry width");
	end

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	fsu_pkg::fsu_sense_s sense;
	logic [2:0] pin_sync;

	fsu_sync #(.WIDTH($bits(fsu_pkg::fsu_sense_s))) u_sense_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(sense_in),
		.sync_out(sense)
	);

	fsu_sync #(.WIDTH(3)) u_pin_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in({lockout_program_pin_elev, lockout_program_pin_high, power_good_pin_hv}),
		.sync_out(pin_sync)
	);

	wire pin_elev = pin_sync[2];
	wire pin_high = pin_sync[1];
	wire pg_hv = pin_sync[0];

	// ----------------------------------------
	// supervisor state machine
	// ----------------------------------------
	fsu_pkg::fsu_sup_e sup_reg;
	fsu_pkg::fsu_sup_e sup_next;
	logic [2:0] ocp_cnt_reg;
	logic [2:0] hic_cnt_reg;
	logic short_reg;

	wire enabled = ctrl_enable & ~lockout_active;
	wire in_start = (sup_reg == fsu_pkg::SUP_START);
	wire in_run = (sup_reg == fsu_pkg::SUP_RUN);
	wire in_hic = (sup_reg == fsu_pkg::SUP_HICCUP);
	wire in_ovh = (sup_reg == fsu_pkg::SUP_OV_HOLD);
	wire in_therm = (sup_reg == fsu_pkg::SUP_THERMAL);
	wire switching = in_start | in_run;

	// limit must hold on every switching edge in a row
	wire ocp_fault = switching & switch_cycle & sense.comp_over_limit
		& (ocp_cnt_reg == 3'(`FSU_OCP_CYCLES - 1));
	wire hic_last = in_hic & soft_start_done & (hic_cnt_reg == 3'(`FSU_HICCUP_CYCLES - 1));
	wire uv_trip = in_run & sense.fb_under_uv;
	wire ov_trip = sense.fb_over_ov & ~in_ovh & ~in_therm;
	wire ov_release = in_ovh & sense.fb_under_uv;

	always_comb begin
		sup_next = sup_reg;
		if (!enabled) begin
			sup_next = fsu_pkg::SUP_OFF;
		end else if (sense.temp_over_shutdown && !in_therm) begin
			sup_next = fsu_pkg::SUP_THERMAL;
		end else if (ov_trip) begin
			sup_next = fsu_pkg::SUP_OV_HOLD;
		end else begin
			case (sup_reg)
				fsu_pkg::SUP_OFF: begin
					sup_next = fsu_pkg::SUP_START;
				end
				fsu_pkg::SUP_START: begin
					if (ocp_fault)
						sup_next = fsu_pkg::SUP_HICCUP;
					else if (soft_start_done)
						sup_next = fsu_pkg::SUP_RUN;
				end
				fsu_pkg::SUP_RUN: begin
					if (ocp_fault || uv_trip)
						sup_next = fsu_pkg::SUP_HICCUP;
				end
				fsu_pkg::SUP_HICCUP: begin
					if (hic_last)
						sup_next = fsu_pkg::SUP_START;
				end
				fsu_pkg::SUP_OV_HOLD: begin
					if (ov_release)
						sup_next = fsu_pkg::SUP_HICCUP;
				end
				fsu_pkg::SUP_THERMAL: begin
					// stays off until the die has cooled past the reset level
					if (sense.temp_below_reset && !sense.temp_over_shutdown)
						sup_next = fsu_pkg::SUP_START;
				end
				default: begin
					sup_next = fsu_pkg::SUP_OFF;
				end
			endcase
		end
	end

	wire enter_hic = (sup_next == fsu_pkg::SUP_HICCUP) & ~in_hic;
	wire voltage_restart = enter_hic & (uv_trip | ov_release);
	wire [2:0] ocp_cnt_next = (!switching || (switch_cycle && !sense.comp_over_limit)) ? 3'h0
		: (switch_cycle ? ocp_cnt_reg + 3'h1 : ocp_cnt_reg);
	wire [2:0] hic_cnt_next = !in_hic ? 3'h0 : (soft_start_done ? hic_cnt_reg + 3'h1 : hic_cnt_reg);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sup_reg <= fsu_pkg::SUP_OFF;
			ocp_cnt_reg <= 3'h0;
			hic_cnt_reg <= 3'h0;
			short_reg <= 1'b0;
			prebias_reset <= 1'b0;
		end else begin
			sup_reg <= sup_next;
			ocp_cnt_reg <= ocp_cnt_next;
			hic_cnt_reg <= hic_cnt_next;
			prebias_reset <= voltage_restart;
			// a fresh short wins over the clear of a finished start
			if (ocp_fault)
				short_reg <= 1'b1;
			else if ((in_start && soft_start_done) || !enabled)
				short_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// drive and status outputs
	// ----------------------------------------
	wire nxt_switch = (sup_next == fsu_pkg::SUP_START) | (sup_next == fsu_pkg::SUP_RUN);
	wire nxt_ovh = (sup_next == fsu_pkg::SUP_OV_HOLD);
	wire nxt_hic = (sup_next == fsu_pkg::SUP_HICCUP);
	wire nxt_start = (sup_next == fsu_pkg::SUP_START);

	// master causes, then the reduced set for a loop slave
	wire pg_master_low = sense.fb_out_of_band | in_start | lockout_active | short_reg
		| sense.temp_over_warn;
	wire pg_slave_low = lockout_active | sense.temp_over_warn;
	wire pg_low = loop_slave ? pg_slave_low : pg_master_low;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			high_side_en <= 1'b0;
			low_side_en <= 1'b0;
			soft_start_run <= 1'b0;
			hiccup_active <= 1'b0;
			thermal_off <= 1'b0;
			power_good_out <= 1'b0;
			power_good_pin_oe <= 1'b1;
		end else begin
			high_side_en <= nxt_switch;
			low_side_en <= nxt_switch | nxt_ovh;
			soft_start_run <= nxt_start | nxt_hic;
			hiccup_active <= nxt_hic;
			thermal_off <= (sup_next == fsu_pkg::SUP_THERMAL);
			power_good_out <= ~pg_low;
			power_good_pin_oe <= pg_low;
		end
	end

	// open drain: only ever pulls low
	assign power_good_pin_out = 1'b0;

	// ----------------------------------------
	// pulse decoder
	// ----------------------------------------
	logic pulse_end;
	logic pulse_is_one;
	logic [CNT_W-1:0] pulse_len;
	logic [CNT_W-1:0] low_len;

	fsu_pulse_meter #(.CNT_W(CNT_W), .ONE_MIN(BIT_ONE_MIN)) u_meter (
		.clk(clk),
		.reset_n(reset_n),
		.level_high(pin_high),
		.pulse_end(pulse_end),
		.pulse_is_one(pulse_is_one),
		.pulse_len(pulse_len),
		.low_len(low_len)
	);

	// ----------------------------------------
	// programming session
	// ----------------------------------------
	fsu_pkg::fsu_prog_e prg_reg;
	fsu_pkg::fsu_prog_e prg_next;
	logic [`FSU_WORD_PULSES-1:0] word_reg;
	logic [2:0] bit_cnt_reg;

	// session needs the elevated or high lockout level and the high power-good level throughout
	wire session_ok = (pin_elev | pin_high) & pg_hv;
	wire entry_seen = pulse_end & (pulse_len >= CNT_W'(`FSU_ENTRY_CYC));
	wire gap_met = ~pin_high & (low_len >= CNT_W'(`FSU_GAP_CYC));
	wire bit_bad = pulse_end & (pulse_len >= CNT_W'(`FSU_BIT_MAX_CYC));
	wire word_stall = (bit_cnt_reg != 3'h0) & (low_len >= CNT_W'(`FSU_BIT_MAX_CYC));
	wire bit_take = (prg_reg == fsu_pkg::PRG_BITS) & pulse_end & ~bit_bad;
	wire word_done = bit_take & (bit_cnt_reg == 3'(`FSU_WORD_PULSES - 1));
	wire [`FSU_WORD_PULSES-1:0] word_full = {word_reg[`FSU_WORD_PULSES-2:0], pulse_is_one};
	wire [`FSU_ADDR_BITS-1:0] word_addr = word_full[`FSU_WORD_PULSES-1:1];
	wire word_data = word_full[0];
	wire addr_ok = (word_addr[`FSU_ADDR_BITS-1:2] == 4'h0);
	wire [1:0] bit_sel = word_addr[1:0];

	always_comb begin
		prg_next = prg_reg;
		if (!session_ok) begin
			prg_next = fsu_pkg::PRG_IDLE;
		end else begin
			case (prg_reg)
				fsu_pkg::PRG_IDLE: begin
					if (entry_seen)
						prg_next = fsu_pkg::PRG_GAP;
				end
				fsu_pkg::PRG_GAP: begin
					if (gap_met)
						prg_next = fsu_pkg::PRG_BITS;
					else if (pin_high)
						prg_next = fsu_pkg::PRG_IDLE;
				end
				fsu_pkg::PRG_BITS: begin
					if (bit_bad)
						prg_next = fsu_pkg::PRG_IDLE;
				end
				default: begin
					prg_next = fsu_pkg::PRG_IDLE;
				end
			endcase
		end
	end

	wire [2:0] bit_cnt_next = (prg_reg != fsu_pkg::PRG_BITS || word_done || word_stall) ? 3'h0
		: (bit_take ? bit_cnt_reg + 3'h1 : bit_cnt_reg);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prg_reg <= fsu_pkg::PRG_IDLE;
			word_reg <= '0;
			bit_cnt_reg <= 3'h0;
		end else begin
			prg_reg <= prg_next;
			bit_cnt_reg <= bit_cnt_next;
			if (bit_take)
				word_reg <= word_full;
		end
	end

	// ----------------------------------------
	// trim buffer and store commit
	// ----------------------------------------
	logic loaded_reg;
	logic [19:0] commit_cnt_reg;
	logic commit_done_reg;
	logic [3:0] buf_bits;
	logic [3:0] buf_next;

	// only these four bits exist on this path; other trims are not addressable
	wire write_ok = word_done & addr_ok & session_ok;
	wire commit_hold = pg_hv & pin_high;
	wire commit_fire = commit_hold & ~commit_done_reg
		& (commit_cnt_reg == 20'(COMMIT_CYC - 1));

	generate
		for (genvar i = 0; i < 4; i++) begin : g_trim_bit
			assign buf_next[i] = (write_ok && bit_sel == 2'(i)) ? word_data : buf_bits[i];
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			buf_bits <= `FSU_TRIM_RESET;
			loaded_reg <= 1'b0;
		end else if (!loaded_reg) begin
			// first edge after release takes the stored code
			buf_bits <= nv_stored_code;
			loaded_reg <= 1'b1;
		end else begin
			buf_bits <= buf_next;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			commit_cnt_reg <= 20'h00000;
			commit_done_reg <= 1'b0;
			nv_write_pulse <= 1'b0;
			nv_write_data <= `FSU_TRIM_RESET;
		end else begin
			commit_cnt_reg <= (commit_hold && !commit_done_reg) ? commit_cnt_reg + 20'h00001 : 20'h00000;
			// one write per hold; releasing the pins re-arms a later commit
			commit_done_reg <= commit_hold & (commit_done_reg | commit_fire);
			nv_write_pulse <= commit_fire;
			if (commit_fire)
				nv_write_data <= buf_bits;
		end
	end

	// ----------------------------------------
	// reference trim outputs
	// ----------------------------------------
	wire [4:0] step_mv = 5'(buf_bits[2:0]) * 5'(`FSU_TRIM_STEP_MV);
	wire signed [4:0] offset_next = buf_bits[3] ? $signed(5'(`FSU_TRIM_TOP_MV) - step_mv)
		: $signed(5'h00 - step_mv);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_trim_code <= `FSU_TRIM_RESET;
			ref_offset_mv <= 5'sh00;
		end else begin
			ref_trim_code <= buf_bits;
			ref_offset_mv <= offset_next;
		end
	end
endmodule : fsu_fault_trim

// ==== tb/fsu_programmer.sv ====
// fsu_programmer: trim programmer model on the lockout and power-good pins
// assumes the bench calls its tasks; levels change just after a rising edge
`timescale 1ns/100ps
module fsu_programmer (
	input wire logic clk,
	output logic elev,
	output logic high,
	output logic hv
);
	// ------
	// pin levels
	// ------
	initial begin
		elev = 1'b0;
		high = 1'b0;
		hv = 1'b0;
	end
	task automatic hold(input logic h, input int n);
		@(posedge clk);
		high <= h;
		repeat (n - 1) @(posedge clk);
	endtask : hold
	task automatic open_session();
		@(posedge clk);
		elev <= 1'b1;
		hv <= 1'b1;
		hold(1'b1, 510);
		hold(1'b0, 410);
	endtask : open_session
	// width 35 or 10 against a 50-cycle period
	task automatic pulse(input logic d);
		hold(1'b1, d ? 35 : 10);
		hold(1'b0, d ? 15 : 40);
	endtask : pulse
	task automatic word(input logic [5:0] a, input logic d);
		for (int i = 5; i >= 0; i--) pulse(a[i]);
		pulse(d);
	endtask : word
	// store wears out: the bench issues one commit only
	task automatic commit(input int n);
		hold(1'b1, n);
		hold(1'b0, 20);
	endtask : commit
	task automatic close_session();
		@(posedge clk);
		elev <= 1'b0;
		hv <= 1'b0;
	endtask : close_session
endmodule : fsu_programmer

// ==== tb/fsu_fault_trim_properties.sv ====
// fsu_fault_trim_checker: timing relations at the supervisor ports
// assumes one clock domain and bind onto fsu_fault_trim
`timescale 1ns/100ps
module fsu_fault_trim_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ctrl_enable,
	input wire logic lockout_active,
	input wire fsu_pkg::fsu_sense_s sense_in,
	input wire logic lockout_program_pin_high,
	input wire logic power_good_pin_hv,
	input wire logic power_good_out,
	input wire logic power_good_pin_out,
	input wire logic power_good_pin_oe,
	input wire logic high_side_en,
	input wire logic low_side_en,
	input wire logic prebias_reset,
	input wire logic hiccup_active,
	input wire logic thermal_off,
	input wire fsu_pkg::fsu_trim_s ref_trim_code,
	input wire logic signed [4:0] ref_offset_mv,
	input wire logic nv_write_pulse,
	input wire fsu_pkg::fsu_trim_s nv_write_data
);
	int mv;
	assign mv = (ref_trim_code[3] ? 14 : 0) - 2 * int'(ref_trim_code[2:0]);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_lockout_pg: assert property ($past(lockout_active) |-> !power_good_out)
		else $error("power good high during lockout");
	a_pin_data: assert property (!power_good_pin_out && (power_good_pin_oe == !power_good_out))
		else $error("power good pin not pulled low exactly when power is not good");
	a_hiccup_quiet: assert property (hiccup_active |-> !high_side_en && !low_side_en)
		else $error("switching during hiccup");
	a_thermal_quiet: assert property (thermal_off |-> !high_side_en && !low_side_en)
		else $error("switching during thermal shutdown");
	a_shutdown_entry: assert property (ctrl_enable && $past(ctrl_enable) && $past(sense_in.temp_over_shutdown, 3)
		&& $past(sense_in.temp_over_shutdown, 4) |-> thermal_off)
		else $error("hot die not shut down");
	a_prebias_pulse: assert property (prebias_reset |-> hiccup_active ##1 !prebias_reset)
		else $error("prebias reset not a hiccup pulse");
	a_commit_once: assert property (nv_write_pulse |=> !nv_write_pulse)
		else $error("commit strobe too long");
	a_commit_cause: assert property (nv_write_pulse |-> $past(power_good_pin_hv, 4)
		&& $past(lockout_program_pin_high, 4))
		else $error("commit without pin hold");
	a_commit_data: assert property (nv_write_pulse |-> nv_write_data == ref_trim_code)
		else $error("commit data differs from buffer");
	a_offset_map: assert property (int'(ref_offset_mv) == mv)
		else $error("offset does not match trim code");
	a_trim_quiet: assert property ($past(reset_n, 3) && !$past(power_good_pin_hv) |-> $stable(ref_trim_code))
		else $error("trim changed outside programming");
endmodule : fsu_fault_trim_checker
bind fsu_fault_trim fsu_fault_trim_checker fsu_fault_trim_checker_inst (.clk, .reset_n, .ctrl_enable,
	.lockout_active, .sense_in, .lockout_program_pin_high, .power_good_pin_hv, .power_good_out,
	.power_good_pin_out, .power_good_pin_oe, .high_side_en, .low_side_en, .prebias_reset, .hiccup_active, .thermal_off,
	.ref_trim_code, .ref_offset_mv, .nv_write_pulse, .nv_write_data);

// ==== tb/tb.sv ====
// tb: self-checking bench for fsu_fault_trim with a trim programmer model
// assumes a 50 MHz clock and a shortened commit count
`timescale 1ns/100ps
module tb;
	localparam int UV = 6, OV = 5, BAND = 4, WARN = 3, SHUT = 2, COOL = 1, OCL = 0;
	logic clk, reset_n, ctrl_enable, loop_slave, lockout_active, sw_cyc, ss_done;
	logic pg, pg_pin, pg_oe, hs, ls, ss_run, pb, hic, thermal, nv_wr, elev, high, hv;
	logic signed [4:0] off_mv;
	fsu_pkg::fsu_sense_s sense;
	fsu_pkg::fsu_trim_s ref_code, nv_data, store, mcode, last;
	fsu_pkg::fsu_trim_s trim_q[$], nv_q[$];
	int errors, total_checks;
	fsu_fault_trim #(.COMMIT_CYC(600)) fsu_fault_trim_inst (.clk(clk), .reset_n(reset_n),
		.ctrl_enable(ctrl_enable), .loop_slave(loop_slave), .lockout_active(lockout_active),
		.sense_in(sense), .switch_cycle(sw_cyc), .soft_start_done(ss_done),
		.lockout_program_pin_elev(elev), .lockout_program_pin_high(high), .power_good_pin_hv(hv),
		.nv_stored_code(store), .power_good_out(pg), .power_good_pin_out(pg_pin),
		.power_good_pin_oe(pg_oe), .high_side_en(hs), .low_side_en(ls), .soft_start_run(ss_run),
		.prebias_reset(pb), .hiccup_active(hic), .thermal_off(thermal), .ref_trim_code(ref_code),
		.ref_offset_mv(off_mv), .nv_write_pulse(nv_wr), .nv_write_data(nv_data));
	fsu_programmer fsu_programmer_inst (.clk(clk), .elev(elev), .high(high), .hv(hv));
	// ------
	// helpers
	// ------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	function automatic logic [4:0] mv(input logic [3:0] c);
		int v;
		v = (c[3] ? 14 : 0) - 2 * int'(c[2:0]);
		return v[4:0];
	endfunction : mv
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic pls(input logic s, input int n);
		repeat (n) begin
			@(posedge clk);
			if (s) sw_cyc <= 1'b1;
			else ss_done <= 1'b1;
			@(posedge clk);
			sw_cyc <= 1'b0;
			ss_done <= 1'b0;
			cyc(2);
		end
	endtask : pls
	task automatic sn(input int f, input logic v);
		@(posedge clk);
		sense[f] <= v;
	endtask : sn
	// note before the word: the write lands before the word task returns
	task automatic wr(input logic [5:0] a, input logic d);
		if (a[5:2] == 4'h0 && mcode[a[1:0]] !== d) begin
			mcode[a[1:0]] = d;
			trim_q.push_back(mcode);
		end
		fsu_programmer_inst.word(a, d);
		cyc(10);
	endtask : wr
	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		cyc(3);
		chk("pg_oe in reset", 8'h1, {7'h0, pg_oe});
		@(posedge clk);
		reset_n <= 1'b1;
		if (store !== 4'h0) trim_q.push_back(store);
		mcode = store;
	endtask : do_reset
	// ------
	// result watcher
	// ------
	always @(negedge clk) begin
		if (!reset_n) last = '0;
		else if (ref_code !== last) begin
			last = ref_code;
			if (trim_q.size() == 0) chk("unexpected trim change", 8'(last), 8'(~last));
			else chk("ref_trim_code", 8'(trim_q.pop_front()), 8'(ref_code));
			chk("ref_offset_mv", {3'h0, mv(ref_code)}, {3'h0, off_mv});
		end
		if (reset_n && nv_wr === 1'b1) begin
			if (nv_q.size() == 0) chk("unexpected commit", 8'h0, 8'h1);
			else chk("nv_write_data", 8'(nv_q.pop_front()), 8'(nv_data));
			store = nv_data;
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		print_verdict();
	end
	// ------
	// main sequence
	// ------
	initial begin
		reset_n = 1'b0;
		{ctrl_enable, loop_slave, lockout_active, sw_cyc, ss_done} = 5'h10;
		sense = 7'h02;
		void'($urandom(31760));
		store = 4'($urandom_range(15, 1));
		do_reset();
		cyc(4);
		chk("start pg", 8'h0, {7'h0, pg});
		pls(1'b0, 1);
		cyc(4);
		chk("run pg", 8'h1, {7'h0, pg});
		for (int m = 0; m < 2; m++) begin
			for (int c = 0; c < 4; c++) begin
				@(posedge clk);
				loop_slave <= m[0];
				lockout_active <= (c == 2);
				sense[BAND] <= (c == 0);
				sense[WARN] <= (c == 1);
				cyc(5);
				// lockout dropped the supervisor back into soft start
				if (c == 3) pls(1'b0, 1);
				chk("pg cause", {7'h0, c == 3 || (m == 1 && c == 0)}, {7'h0, pg});
			end
		end
		loop_slave <= 1'b0;
		sn(UV, 1'b1);
		sn(UV, 1'b0);
		cyc(4);
		chk("uv hiccup", 8'h1, {7'h0, hic});
		pls(1'b0, 6);
		chk("hiccup count", 8'h1, {7'h0, hic});
		pls(1'b0, 1);
		cyc(2);
		chk("hiccup end", 8'h2, {6'h0, ss_run, hic});
		pls(1'b0, 1);
		sn(OV, 1'b1);
		sn(OV, 1'b0);
		cyc(12);
		chk("ov hold", 8'h1, {6'h0, hs, ls});
		sn(UV, 1'b1);
		cyc(4);
		chk("ov release", 8'h1, {6'h0, ls, hic});
		sn(OV, 1'b1);
		sn(UV, 1'b0);
		cyc(4);
		chk("ov in hiccup", 8'h1, {7'h0, ls});
		sn(OV, 1'b0);
		sn(UV, 1'b1);
		sn(UV, 1'b0);
		cyc(4);
		pls(1'b0, 8);
		sn(OCL, 1'b1);
		cyc(4);
		pls(1'b1, 6);
		chk("ocp six", 8'h0, {7'h0, hic});
		pls(1'b1, 1);
		cyc(2);
		chk("ocp seven", 8'h1, {6'h0, pg, hic});
		sn(OCL, 1'b0);
		pls(1'b0, 8);
		chk("restart pg", 8'h1, {7'h0, pg});
		sn(SHUT, 1'b1);
		sn(COOL, 1'b0);
		cyc(5);
		chk("hot", 8'h1, {7'h0, thermal});
		sn(SHUT, 1'b0);
		cyc(8);
		chk("cooling", 8'h1, {7'h0, thermal});
		sn(COOL, 1'b1);
		cyc(5);
		chk("cooled", 8'h0, {7'h0, thermal});
		fsu_programmer_inst.open_session();
		for (int i = 0; i < 4; i++) wr(6'(i), 1'($urandom));
		wr(6'($urandom_range(63, 4)), 1'($urandom));
		for (int i = 0; i < 3; i++) fsu_programmer_inst.pulse(!mcode[0]);
		fsu_programmer_inst.hold(1'b1, 250);
		fsu_programmer_inst.hold(1'b0, 50);
		fsu_programmer_inst.open_session();
		wr(6'h3, !mcode[3]);
		nv_q.push_back(mcode);
		fsu_programmer_inst.commit(620);
		fsu_programmer_inst.open_session();
		wr(6'h0, !mcode[0]);
		fsu_programmer_inst.close_session();
		cyc(10);
		do_reset();
		cyc(5);
		chk("trim after reset", 8'(store), 8'(ref_code));
		chk("queues drained", 8'h0, 8'(trim_q.size() + nv_q.size()));
		print_verdict();
	end
endmodule : tb
